// File: shared/sbpc_pkg.sv
// Purpose: Shared constants and types for the SDRAM burst and power logic
// Assumes: One 100 MHz clock, synchronous active-low reset
// Notes: Command codes follow {cs_n, ras_n, cas_n, we_n}
package sbpc_pkg;
  // ---------------------------------------------------------------
  // Geometry
  // ---------------------------------------------------------------
  localparam int DQ_W = 16;
  localparam int ROW_W = 13;
  localparam int COL_W = 9;
  localparam int ADDR_W = 13;
  localparam int BANKS = 4;
  localparam int PSEL_BIT = 10;
  localparam int AP_BIT = 10;
  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 10;
  localparam int PRECHARGE_PERIOD_NS = 18;
  localparam int WRITE_RECOVERY_NS = 15;
  localparam int PRECHARGE_PERIOD_CYC =
    (PRECHARGE_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WRITE_RECOVERY_CYC =
    (WRITE_RECOVERY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int DQM_READ_LATENCY = 2;
  localparam int CAS_LAT_MAX = 3;
  // ---------------------------------------------------------------
  // Mode word fields and reset values
  // ---------------------------------------------------------------
  localparam int MODE_BL_LSB = 0;
  localparam int MODE_CL_LSB = 4;
  localparam int MODE_WBM_BIT = 9;
  localparam logic [2:0] BL_FULL = 3'h7;
  localparam logic [12:0] MODE_RESET = 13'h0022;
  localparam logic [3:0] CMD_RESET = 4'hF;
  // ---------------------------------------------------------------
  // Commands
  // ---------------------------------------------------------------
  typedef enum logic [3:0] {
    CMD_INHIBIT = 4'h8,
    CMD_NOP = 4'h7,
    CMD_ACTIVE = 4'h3,
    CMD_READ = 4'h5,
    CMD_WRITE = 4'h4,
    CMD_BURST_STOP = 4'h6,
    CMD_PRECHARGE = 4'h2,
    CMD_REFRESH = 4'h1,
    CMD_LOAD_MODE = 4'h0
  } sbpc_cmd_t;
  // Gray-coded device states along idle -> read -> write -> suspend -> power-down
  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_READ = 3'h1,
    ST_WRITE = 3'h3,
    ST_SUSPEND = 3'h2,
    ST_POWER_DOWN = 3'h6
  } sbpc_state_t;
endpackage

// File: shared/sbpc_if.sv
// Purpose: Pin bundle between controller and memory
// Assumes: DQ is resolved from the two output enables
// Notes: No clocking block; both ends are plain synchronous logic
`timescale 1ns/1ps
`default_nettype none
interface sbpc_if;
  logic cke;
  logic [3:0] cmd;
  logic [sbpc_pkg::ADDR_W-1:0] addr;
  logic bank_select_lo;
  logic bank_select_hi;
  logic dqm;
  logic [sbpc_pkg::DQ_W-1:0] ctl_dq_out;
  logic ctl_dq_oe;
  logic [sbpc_pkg::DQ_W-1:0] mem_dq_out;
  logic mem_dq_oe;
  logic [sbpc_pkg::DQ_W-1:0] dq;
  assign dq = ctl_dq_oe ? ctl_dq_out : mem_dq_oe ? mem_dq_out : '0;
  modport ctl (
    output cke, cmd, addr, bank_select_lo, bank_select_hi, dqm,
    output ctl_dq_out, ctl_dq_oe,
    input dq
  );
  modport mem (
    input cke, cmd, addr, bank_select_lo, bank_select_hi, dqm,
    output mem_dq_out, mem_dq_oe,
    input dq
  );
endinterface
`default_nettype wire

// File: src/sbpc_read_pipe.sv
// Purpose: CAS-latency and DQM delay line for read data output
// Assumes: Advances only on enabled internal edges
// Notes: Latency 1..3 selected at run time
`timescale 1ns/1ps
`default_nettype none
module sbpc_read_pipe (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic adv_i,
  // Control
  input wire logic [1:0] cas_lat_i,
  input wire logic dqm_i,
  input wire logic kill_i,
  input wire logic valid_i,
  input wire logic [sbpc_pkg::DQ_W-1:0] data_i,
  // Output
  output logic valid_o,
  output logic [sbpc_pkg::DQ_W-1:0] data_o
);
  localparam int N = sbpc_pkg::CAS_LAT_MAX;
  logic [N-1:0] vld;
  logic [N-1:0] next_vld;
  logic [sbpc_pkg::DQ_W-1:0] dat [N];
  logic [sbpc_pkg::DQ_W-1:0] next_dat [N];
  logic [1:0] dqm_d;
  logic [1:0] next_dqm_d;
  // ---------------------------------------------------------------
  // Shift chain
  // ---------------------------------------------------------------
  always_comb begin
    next_vld = vld;
    next_dat = dat;
    next_dqm_d = dqm_d;
    if (adv_i) begin
      next_dqm_d = {dqm_d[0], dqm_i};
      next_vld[0] = valid_i;
      next_dat[0] = data_i;
      for (int i = 1; i < N; i++) begin
        next_vld[i] = vld[i-1];
        next_dat[i] = dat[i-1];
      end
    end
    // Write takes the bus: pending read words are dropped
    if (kill_i) begin
      next_vld = '0;
    end
  end
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      vld <= '0;
      dqm_d <= '0;
      for (int i = 0; i < N; i++) begin
        dat[i] <= '0;
      end
    end else begin
      vld <= next_vld;
      dat <= next_dat;
      dqm_d <= next_dqm_d;
    end
  end
  // Mask acts two edges late on outputs
  always_comb begin
    valid_o = vld[cas_lat_i - 2'h1] && !dqm_d[1];
    data_o = dat[cas_lat_i - 2'h1];
  end
endmodule
`default_nettype wire

// File: src/sbpc_mem.sv
// Purpose: Memory end: command decode, bursts, power-down, suspend
// Assumes: Controller keeps its own timing; array is small
// Notes: Array holds 4 banks x 2^COL_W words of the open row only
`timescale 1ns/1ps
`default_nettype none
module sbpc_mem (
  // Clock and reset
  input wire logic CORE_CLK_I,
  input wire logic RST_B_I,
  // Link
  sbpc_if.mem LINK,
  // Status
  output logic POWER_DOWN_O,
  output logic ACTIVE_POWER_DOWN_O,
  output logic SUSPEND_O
);
  localparam int CW = sbpc_pkg::COL_W;
  localparam int DW = sbpc_pkg::DQ_W;
  logic [DW-1:0] mem [sbpc_pkg::BANKS * (2 ** CW)];
  sbpc_pkg::sbpc_state_t st, next_st;
  logic [sbpc_pkg::BANKS-1:0] open, next_open;
  logic [sbpc_pkg::BANKS-1:0] ap_wait, next_ap_wait;
  logic [1:0] wr_rec, next_wr_rec;
  logic [1:0] bank, next_bank;
  logic [CW-1:0] col, next_col;
  logic [8:0] left, next_left;
  logic full, next_full;
  logic ap, next_ap;
  logic [12:0] mode, next_mode;
  logic wr_en;
  logic [CW+1:0] wr_addr;
  logic rd_valid;
  logic pipe_valid;
  logic [DW-1:0] pipe_data;
  logic kill;
  logic dq_oe, next_dq_oe;
  logic [DW-1:0] dq_out, next_dq_out;
  logic pd, next_pd;
  logic apd, next_apd;
  logic sus, next_sus;
  logic [3:0] cmd;
  logic adv;
  // Burst length from mode field, 0 means full page
  function automatic logic [8:0] burst_len(input logic [2:0] f);
    case (f)
      3'h0: burst_len = 9'h001;
      3'h1: burst_len = 9'h002;
      3'h2: burst_len = 9'h004;
      3'h3: burst_len = 9'h008;
      default: burst_len = 9'h000;
    endcase
  endfunction
  // Bank mask selected by a precharge
  function automatic logic [3:0] pre_mask(input logic all,
                                          input logic [1:0] b);
    pre_mask = all ? 4'hF : (4'h1 << b);
  endfunction
  assign cmd = LINK.cmd[3] ? sbpc_pkg::CMD_INHIBIT : LINK.cmd;
  // Internal edge runs unless the previous edge saw CKE low in a burst
  assign adv = !sus;
  // ---------------------------------------------------------------
  // Command and burst state
  // ---------------------------------------------------------------
  always_comb begin
    next_st = st;
    next_open = open;
    next_ap_wait = ap_wait;
    next_wr_rec = wr_rec;
    next_bank = bank;
    next_col = col;
    next_left = left;
    next_full = full;
    next_ap = ap;
    next_mode = mode;
    next_pd = pd;
    next_apd = apd;
    next_sus = 1'b0;
    wr_en = 1'b0;
    wr_addr = {bank, col};
    rd_valid = 1'b0;
    kill = 1'b0;
    // Auto precharge waits out write recovery
    if (|ap_wait) begin
      if (wr_rec != 2'h0) begin
        next_wr_rec = wr_rec - 2'h1;
      end else begin
        next_open = open & ~ap_wait;
        next_ap_wait = '0;
      end
    end
    if (pd) begin
      // Buffers off; only a nop or inhibit with CKE high brings it back
      if (LINK.cke && (cmd == sbpc_pkg::CMD_NOP ||
                       cmd == sbpc_pkg::CMD_INHIBIT)) begin
        next_pd = 1'b0;
        next_apd = 1'b0;
      end
    end else if (sus) begin
      // Frozen edge: inputs ignored, burst counters and outputs held
      next_sus = !LINK.cke;
    end else begin
      if (st != sbpc_pkg::ST_IDLE && !LINK.cke) begin
        next_sus = 1'b1;
      end
      // Burst progress
      if (st == sbpc_pkg::ST_READ || st == sbpc_pkg::ST_WRITE) begin
        if (st == sbpc_pkg::ST_WRITE && !LINK.dqm) begin
          wr_en = 1'b1;
        end
        rd_valid = (st == sbpc_pkg::ST_READ);
        next_col = col + 1'b1;
        if (!full) begin
          next_left = left - 9'h001;
          if (left == 9'h001) begin
            next_st = sbpc_pkg::ST_IDLE;
            if (ap && st == sbpc_pkg::ST_WRITE) begin
              next_ap_wait = 4'h1 << bank;
              next_wr_rec = 2'(sbpc_pkg::WRITE_RECOVERY_CYC - 1);
            end else if (ap) begin
              next_open[bank] = 1'b0;
            end
          end
        end
      end
      case (cmd)
        sbpc_pkg::CMD_ACTIVE: begin
          next_open[{LINK.bank_select_hi, LINK.bank_select_lo}] = 1'b1;
        end
        sbpc_pkg::CMD_READ, sbpc_pkg::CMD_WRITE: begin
          if (open[{LINK.bank_select_hi, LINK.bank_select_lo}]) begin
            next_bank = {LINK.bank_select_hi, LINK.bank_select_lo};
            next_col = LINK.addr[CW-1:0];
            next_ap = LINK.addr[sbpc_pkg::AP_BIT];
            next_full = burst_len(mode[2:0]) == 9'h000;
            next_left = burst_len(mode[2:0]);
            next_st = sbpc_pkg::ST_READ;
            if (cmd == sbpc_pkg::CMD_WRITE) begin
              kill = 1'b1;
              next_st = sbpc_pkg::ST_WRITE;
              if (mode[sbpc_pkg::MODE_WBM_BIT]) begin
                next_full = 1'b0;
                next_left = 9'h001;
              end
              if (!LINK.dqm) begin
                wr_en = 1'b1;
                wr_addr = {LINK.bank_select_hi, LINK.bank_select_lo,
                           LINK.addr[CW-1:0]};
              end
              next_col = LINK.addr[CW-1:0] + 1'b1;
              next_left = next_left - 9'h001;
              if (next_left == 9'h000 && !next_full) begin
                next_st = sbpc_pkg::ST_IDLE;
                if (next_ap) begin
                  next_ap_wait = 4'h1 <<
                    {LINK.bank_select_hi, LINK.bank_select_lo};
                  next_wr_rec = 2'(sbpc_pkg::WRITE_RECOVERY_CYC - 1);
                end
              end
            end
          end
        end
        sbpc_pkg::CMD_BURST_STOP: begin
          if (st == sbpc_pkg::ST_WRITE) begin
            wr_en = 1'b0;
          end
          next_st = sbpc_pkg::ST_IDLE;
        end
        sbpc_pkg::CMD_PRECHARGE: begin
          next_open = next_open & ~pre_mask(LINK.addr[sbpc_pkg::PSEL_BIT],
            {LINK.bank_select_hi, LINK.bank_select_lo});
          // A precharge to the bank in a burst ends that burst
          if ((LINK.addr[sbpc_pkg::PSEL_BIT] ||
               {LINK.bank_select_hi, LINK.bank_select_lo} == bank) &&
              st != sbpc_pkg::ST_IDLE) begin
            next_st = sbpc_pkg::ST_IDLE;
          end
        end
        sbpc_pkg::CMD_LOAD_MODE: begin
          next_mode = LINK.addr;
        end
        sbpc_pkg::CMD_NOP, sbpc_pkg::CMD_INHIBIT: begin
          if (!LINK.cke && st == sbpc_pkg::ST_IDLE) begin
            next_pd = 1'b1;
            next_apd = |next_open;
            next_sus = 1'b0;
          end
        end
        default: begin
        end
      endcase
    end
  end
  always_ff @(posedge CORE_CLK_I) begin
    if (!RST_B_I) begin
      st <= sbpc_pkg::ST_IDLE;
      open <= '0;
      ap_wait <= '0;
      wr_rec <= '0;
      bank <= '0;
      col <= '0;
      left <= '0;
      full <= 1'b0;
      ap <= 1'b0;
      mode <= sbpc_pkg::MODE_RESET;
      pd <= 1'b0;
      apd <= 1'b0;
      sus <= 1'b0;
    end else begin
      st <= next_st;
      open <= next_open;
      ap_wait <= next_ap_wait;
      wr_rec <= next_wr_rec;
      bank <= next_bank;
      col <= next_col;
      left <= next_left;
      full <= next_full;
      ap <= next_ap;
      mode <= next_mode;
      pd <= next_pd;
      apd <= next_apd;
      sus <= next_sus;
    end
  end
  // Array write port; no reset so it maps to memory
  always_ff @(posedge CORE_CLK_I) begin
    if (wr_en) begin
      mem[wr_addr] <= LINK.dq;
    end
  end
  // ---------------------------------------------------------------
  // Read data path
  // ---------------------------------------------------------------
  sbpc_read_pipe u_pipe (.clk_i(CORE_CLK_I), .rst_b_i(RST_B_I),
    .adv_i(adv), .cas_lat_i(mode[5:4]), .dqm_i(LINK.dqm),
    .kill_i(kill), .valid_i(rd_valid), .data_i(mem[{bank, col}]),
    .valid_o(pipe_valid), .data_o(pipe_data));
  always_comb begin
    next_dq_oe = pipe_valid && !kill && !pd;
    next_dq_out = pipe_data;
    if (sus) begin
      next_dq_oe = dq_oe;
      next_dq_out = dq_out;
    end
  end
  always_ff @(posedge CORE_CLK_I) begin
    if (!RST_B_I) begin
      dq_oe <= 1'b0;
      dq_out <= '0;
      POWER_DOWN_O <= 1'b0;
      ACTIVE_POWER_DOWN_O <= 1'b0;
      SUSPEND_O <= 1'b0;
    end else begin
      dq_oe <= next_dq_oe;
      dq_out <= next_dq_out;
      POWER_DOWN_O <= next_pd;
      ACTIVE_POWER_DOWN_O <= next_apd;
      SUSPEND_O <= next_sus;
    end
  end
  assign LINK.mem_dq_oe = dq_oe;
  assign LINK.mem_dq_out = dq_out;
endmodule
`default_nettype wire

// File: src/sbpc_ctl.sv
// Purpose: Controller end: drives one command per request
// Assumes: User spaces requests per precharge period, CL-1 and mask lead
// Notes: Pins come straight from flip-flops
`timescale 1ns/1ps
`default_nettype none
module sbpc_ctl (
  // Clock and reset
  input wire logic CORE_CLK_I,
  input wire logic RST_B_I,
  // User request
  input wire logic REQ_I,
  input wire logic [3:0] CMD_I,
  input wire logic [12:0] ADDR_I,
  input wire logic [1:0] BANK_I,
  input wire logic CKE_I,
  input wire logic DQM_I,
  input wire logic DQ_OE_I,
  input wire logic [15:0] DQ_I,
  // Returned data
  output logic [15:0] DQ_O,
  // Link
  sbpc_if.ctl LINK
);
  logic [3:0] cmd, next_cmd;
  logic [12:0] addr, next_addr;
  logic [1:0] bank, next_bank;
  logic cke, dqm, oe;
  logic [15:0] dout, din;
  // Request becomes a command; idle cycles send a nop
  always_comb begin
    next_cmd = REQ_I ? CMD_I : sbpc_pkg::CMD_NOP;
    next_addr = REQ_I ? ADDR_I : '0;
    next_bank = REQ_I ? BANK_I : '0;
  end
  always_ff @(posedge CORE_CLK_I) begin
    if (!RST_B_I) begin
      cmd <= sbpc_pkg::CMD_RESET;
      addr <= '0;
      bank <= '0;
      cke <= 1'b1;
      dqm <= 1'b1;
      oe <= 1'b0;
      dout <= '0;
      din <= '0;
    end else begin
      cmd <= next_cmd;
      addr <= next_addr;
      bank <= next_bank;
      cke <= CKE_I;
      dqm <= DQM_I;
      oe <= DQ_OE_I;
      dout <= DQ_I;
      din <= LINK.dq;
    end
  end
  assign LINK.cmd = cmd;
  assign LINK.addr = addr;
  assign LINK.bank_select_lo = bank[0];
  assign LINK.bank_select_hi = bank[1];
  assign LINK.cke = cke;
  assign LINK.dqm = dqm;
  assign LINK.ctl_dq_oe = oe;
  assign LINK.ctl_dq_out = dout;
  assign DQ_O = din;
endmodule
`default_nettype wire

// File: sim/sbpc_props.sv
// Purpose: Link-level checks between controller and memory ends
// Assumes: Watches sbpc_if signals, one clock domain
// Notes: Bank-open state is rebuilt here from the command stream
`timescale 1ns/1ps
`default_nettype none
module sbpc_props (
  // Clock and reset
  input wire logic CORE_CLK_I,
  input wire logic RST_B_I,
  // Link
  input wire logic cke,
  input wire logic [3:0] cmd,
  input wire logic [12:0] addr,
  input wire logic bank_select_lo,
  input wire logic bank_select_hi,
  input wire logic dqm,
  input wire logic mem_dq_oe,
  input wire logic [15:0] mem_dq_out
);
  // ---------------------------------------------------------------
  // Bank tracking
  // ---------------------------------------------------------------
  logic [3:0] open_b;
  logic [3:0] next_open_b;
  logic cke_q;
  logic [1:0] bk;
  assign bk = {bank_select_hi, bank_select_lo};
  // A command counts only when the previous edge saw clock-enable high
  always_comb begin
    next_open_b = open_b;
    if (cke_q && cmd == sbpc_pkg::CMD_ACTIVE) next_open_b[bk] = 1'b1;
    if (cke_q && cmd == sbpc_pkg::CMD_WRITE && addr[10]) begin
      next_open_b[bk] = 1'b0;
    end
    if (cke_q && cmd == sbpc_pkg::CMD_PRECHARGE) begin
      if (addr[10]) next_open_b = 4'h0;
      else next_open_b[bk] = 1'b0;
    end
  end
  always_ff @(posedge CORE_CLK_I) begin
    if (!RST_B_I) begin
      open_b <= 4'h0;
      cke_q <= 1'b1;
    end else begin
      open_b <= next_open_b;
      cke_q <= cke;
    end
  end
  // ---------------------------------------------------------------
  // Properties
  // ---------------------------------------------------------------
  default clocking @(posedge CORE_CLK_I); endclocking
  default disable iff (!RST_B_I);
  sequence s_silent;
    !mem_dq_oe [*3];
  endsequence
  sequence s_ends;
    ##[1:5] !mem_dq_oe ##1 s_silent;
  endsequence
  sequence s_read_ok;
    cke_q && cke && !dqm && cmd == sbpc_pkg::CMD_READ && open_b[bk];
  endsequence
  AST_READ_ANSWER: assert property (s_read_ok |-> ##[2:6] mem_dq_oe)
    else $error("read to open bank gave no data");
  AST_CLOSED_BANK: assert property (cke_q && !open_b[bk] && !mem_dq_oe &&
    cmd == sbpc_pkg::CMD_READ |=> s_silent ##1 s_silent)
    else $error("read to closed bank drove data");
  AST_WRITE_FLOATS: assert property (cke_q && $past(dqm) &&
    cmd == sbpc_pkg::CMD_WRITE |=> !mem_dq_oe [*2])
    else $error("memory drove data after write");
  AST_SUSPEND_HOLD: assert property (!cke && mem_dq_oe |->
    ##2 ($stable(mem_dq_oe) && $stable(mem_dq_out)))
    else $error("output moved during suspend");
  AST_STOP_ENDS: assert property (cke_q &&
    cmd == sbpc_pkg::CMD_BURST_STOP |-> s_ends)
    else $error("burst stop did not end read data");
  AST_PRECHARGE_ENDS: assert property (cke_q &&
    cmd == sbpc_pkg::CMD_PRECHARGE |-> s_ends)
    else $error("precharge did not end read data");
  AST_DQM_READ: assert property (dqm && $past(dqm) |-> ##2 !mem_dq_oe)
    else $error("mask did not float read output");
  AST_POWER_DOWN: assert property (cke_q && !cke && !mem_dq_oe &&
    (cmd[3] || cmd == sbpc_pkg::CMD_NOP) |=> s_silent)
    else $error("output driven in power-down");
endmodule
`default_nettype wire

// File: sim/test_sdram_burst_and_power_control.sv
// Purpose: Self-checking bench for the controller and memory pair
// Assumes: Ends joined by sbpc_if; page of 512 columns
// Notes: Expected array is kept by the bench from the write stimulus
`timescale 1ns/1ps
`default_nettype none
module test_sdram_burst_and_power_control;
  // ---------------------------------------------------------------
  // Signals
  // ---------------------------------------------------------------
  logic clk, rst_b, req, cke, dqm, oe, pd, apd, susp;
  logic [3:0] cmd;
  logic [12:0] addr;
  logic [1:0] bank;
  logic [15:0] d, dq_o;
  logic [15:0] m [4][512];
  logic [15:0] q [$];
  int errors, total_checks, sus_cnt;
  sbpc_if link ();
  sbpc_ctl u_sbpc_ctl (.CORE_CLK_I(clk), .RST_B_I(rst_b), .REQ_I(req),
    .CMD_I(cmd), .ADDR_I(addr), .BANK_I(bank), .CKE_I(cke), .DQM_I(dqm),
    .DQ_OE_I(oe), .DQ_I(d), .DQ_O(dq_o), .LINK(link));
  sbpc_mem u_sbpc_mem (.CORE_CLK_I(clk), .RST_B_I(rst_b), .LINK(link),
    .POWER_DOWN_O(pd), .ACTIVE_POWER_DOWN_O(apd), .SUSPEND_O(susp));
  sbpc_props u_sbpc_props (.CORE_CLK_I(clk), .RST_B_I(rst_b),
    .cke(link.cke), .cmd(link.cmd), .addr(link.addr),
    .bank_select_lo(link.bank_select_lo),
    .bank_select_hi(link.bank_select_hi), .dqm(link.dqm),
    .mem_dq_oe(link.mem_dq_oe), .mem_dq_out(link.mem_dq_out));
  // ---------------------------------------------------------------
  // Tasks
  // ---------------------------------------------------------------
  task automatic final_report;
    $display("checks %0d mismatches %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic check(logic [15:0] seen, logic [15:0] exp);
    #1;
    total_checks++;
    if (seen !== exp) begin
      errors++;
      $display("wrong value at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask
  task automatic cyc(logic r, logic [3:0] c, logic [12:0] a,
                     logic [1:0] b, logic k, logic mk, logic o,
                     logic [15:0] dd);
    @(posedge clk);
    req <= r;
    cmd <= c;
    addr <= a;
    bank <= b;
    cke <= k;
    dqm <= mk;
    oe <= o;
    d <= dd;
  endtask
  task automatic op(logic [3:0] c, logic [12:0] a, logic [1:0] b);
    cyc(1'b1, c, a, b, 1'b1, 1'b0, 1'b0, 16'h0000);
  endtask
  task automatic idle(int n);
    repeat (n) cyc(1'b0, 4'h7, 13'h0, 2'h0, 1'b1, 1'b0, 1'b0, 16'h0);
  endtask
  task automatic act(logic [1:0] b);
    op(sbpc_pkg::CMD_ACTIVE, 13'h0, b);
    idle(2);
  endtask
  task automatic mode(logic [12:0] v);
    op(sbpc_pkg::CMD_PRECHARGE, 13'h0400, 2'h0);
    idle(2);
    op(sbpc_pkg::CMD_LOAD_MODE, v, 2'h0);
    idle(2);
  endtask
  // Only the first lim words can land; the rest must be dropped
  task automatic wr(logic [1:0] b, int col, int n, logic [7:0] mk,
                    int lim);
    logic [15:0] w;
    for (int i = 0; i < n; i++) begin
      w = 16'($urandom);
      cyc(i == 0, sbpc_pkg::CMD_WRITE, 13'(col), b, 1'b1, mk[i], 1'b1, w);
      if (i < lim && !mk[i]) m[b][(col + i) % 512] = w;
    end
  endtask
  // Suspended edges repeat a word on the pins, so repeats are folded
  task automatic rd(logic [1:0] b, int col, int n, logic [3:0] tc,
                    int at, int sl);
    q.delete();
    op(sbpc_pkg::CMD_READ, 13'(col), b);
    if (sl > 0) idle(3);
    repeat (sl) cyc(1'b0, 4'h7, 13'h0, b, 1'b0, 1'b0, 1'b0, 16'h0);
    if (at > 0) idle(at - 1);
    if (at > 0) op(tc, 13'h0, b);
    idle(12);
    if (sl > 0) begin
      for (int i = q.size() - 1; i > 0; i--) begin
        if (q[i] === q[i - 1]) q.delete(i);
      end
    end
    check(16'(q.size()), 16'(n));
    foreach (q[i]) check(q[i], m[b][(col + i) % 512]);
  endtask
  always @(posedge clk) if (link.mem_dq_oe) q.push_back(link.dq);
  always @(posedge clk) if (susp === 1'b1) sus_cnt++;
  // ---------------------------------------------------------------
  // Clock, watchdog and tests
  // ---------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial begin
    repeat (6000) @(posedge clk);
    errors++;
    final_report();
  end
  initial begin
    errors = 0;
    total_checks = 0;
    void'($urandom(53));
    {rst_b, req, cmd, addr, bank, cke, dqm, oe, d} = '0;
    repeat (12) @(posedge clk);
    check({12'h000, link.cmd}, 16'h000F);
    check({12'h000, link.cke, link.dqm, link.ctl_dq_oe, link.mem_dq_oe},
          16'h000C);
    rst_b <= 1'b1;
    for (int cl = 1; cl <= 3; cl++) begin
      mode({7'h00, 2'(cl), 4'h2});
      act(2'(cl));
      wr(2'(cl), 4, 4, 8'h00, 4);
      wr(2'(cl), 0, 6, 8'h02, 4);
      idle(1);
      rd(2'(cl), 0, 4, 4'h7, 0, 0);
      rd(2'(cl), 4, 4, 4'h7, 0, 0);
      $display("done: write and read, cas latency %0d", cl);
    end
    mode(13'h0222);
    act(2'h2);
    wr(2'h2, 4, 4, 8'h00, 1);
    idle(1);
    rd(2'h2, 4, 4, 4'h7, 0, 0);
    mode(13'h0027);
    act(2'h1);
    wr(2'h1, 510, 2, 8'h00, 512);
    cyc(1'b1, sbpc_pkg::CMD_BURST_STOP, 13'h0, 2'h1, 1'b1, 1'b0, 1'b1,
        ~m[1][0]);
    idle(1);
    rd(2'h1, 510, 4, sbpc_pkg::CMD_BURST_STOP, 4, 0);
    $display("done: single write mode and full page");
    mode(13'h0022);
    act(2'h1);
    act(2'h2);
    rd(2'h1, 0, 2, sbpc_pkg::CMD_PRECHARGE, 2, 0);
    rd(2'h1, 0, 0, 4'h7, 0, 0);
    rd(2'h2, 0, 4, 4'h7, 0, 0);
    q.delete();
    op(sbpc_pkg::CMD_READ, 13'h0, 2'h2);
    idle(1);
    repeat (2) cyc(1'b0, 4'h7, 13'h0, 2'h2, 1'b1, 1'b1, 1'b0, 16'h0);
    wr(2'h2, 0, 4, 8'h00, 4);
    idle(10);
    check(16'(q.size()), 16'h0001);
    rd(2'h2, 0, 4, 4'h7, 0, 0);
    sus_cnt = 0;
    rd(2'h2, 4, 4, 4'h7, 0, 2);
    check(16'(sus_cnt), 16'h0002);
    act(2'h3);
    wr(2'h3, 1024, 4, 8'h00, 4);
    idle(6);
    rd(2'h3, 0, 0, 4'h7, 0, 0);
    $display("done: truncation, turnaround and suspend");
    for (int k = 0; k < 2; k++) begin
      if (k == 1) op(sbpc_pkg::CMD_PRECHARGE, 13'h0400, 2'h0);
      idle(2);
      repeat (4) cyc(1'b0, 4'h7, 13'h0, 2'h0, 1'b0, 1'b0, 1'b0, 16'h0);
      check({14'h0000, pd, apd}, {14'h0000, 1'b1, k == 0});
      idle(4);
      check({15'h0000, pd}, 16'h0000);
    end
    $display("done: power-down entry and exit");
    final_report();
  end
endmodule
`default_nettype wire
